// >>> rtl/ftcfg_pkg.sv
// package: offsets, opcodes, field layout and timing of the hit and event config
package ftcfg_pkg;
  localparam int          REG_W         = 16;
  localparam int          NUM_REGS      = 5;
  localparam int          WAVE_W        = 6;
  localparam int          THR_W         = 12;
  // register offsets; write opcode is the offset, read opcode sets bit 7
  localparam logic [7:0]  OFF_HIT_3_4   = 8'h3b;
  localparam logic [7:0]  OFF_HIT_5_6   = 8'h3c;
  localparam logic [7:0]  OFF_UP_OFS    = 8'h3d;
  localparam logic [7:0]  OFF_DN_OFS    = 8'h3e;
  localparam logic [7:0]  OFF_SCHED     = 8'h3f;
  localparam logic [7:0]  READ_FLAG     = 8'h80;
  localparam logic [15:0] REG_RESET     = 16'h0000;
  // writable bits; all others are reserved
  localparam logic [15:0] MASK_HIT      = 16'h3f3f;
  localparam logic [15:0] MASK_OFS      = 16'hff7f;
  localparam logic [15:0] MASK_SCHED    = 16'hfffe;
  // field positions
  localparam int          HI_WAVE_LSB   = 8;
  localparam int          LO_WAVE_LSB   = 0;
  localparam int          RET_LSB       = 8;
  localparam int          INIT_LSB      = 0;
  localparam int          DIFF_INT_LSB  = 12;
  localparam int          DIFF_CYC_LSB  = 7;
  localparam int          TEMP_INT_LSB  = 1;
  // earliest wave usable per hit
  localparam logic [5:0]  HIT3_MIN      = 6'h05;
  localparam logic [5:0]  HIT4_MIN      = 6'h06;
  localparam logic [5:0]  HIT5_MIN      = 6'h07;
  localparam logic [5:0]  HIT6_MIN      = 6'h08;
  // comparator threshold bases
  localparam logic [11:0] THR_POS_BASE  = 12'h480;
  localparam logic [11:0] THR_NEG_BASE  = 12'h47f;
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int          DIFF_STEP_MS  = 500;
  localparam int          TEMP_STEP_MS  = 1000;
  localparam int          SPI_FRAME     = 24;
  typedef enum logic [1:0] {
    FTCFG_IDLE   = 2'b00,
    FTCFG_BOTH   = 2'b01,
    FTCFG_FLIGHT = 2'b10,
    FTCFG_TEMP   = 2'b11
  } ftcfg_mode_t;
endpackage : ftcfg_pkg

// >>> rtl/ftcfg_wave_clamp.sv
// module: clamps a hit wave code to the earliest usable wave
`timescale 1ns/1ns
module ftcfg_wave_clamp #(
  parameter logic [5:0] MIN_WAVE = 6'h05
) (
  input  wire logic [5:0] code_i,
  output logic      [5:0] wave_o
);
  // small codes all map to the floor, larger ones pass through
  assign wave_o = (code_i < MIN_WAVE) ? MIN_WAVE : code_i;
endmodule : ftcfg_wave_clamp

// >>> rtl/ftcfg_top.sv
// module: hit wave, comparator offset and event schedule config over spi
`timescale 1ns/1ns
module ftcfg_top #(
  parameter int CYC_PER_MS = ftcfg_pkg::CYC_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic        stop_edge_polarity_i,
  input  wire logic [2:0]  stop_hits_i,
  input  wire logic        measure_up_i,
  input  wire logic        early_edge_seen_i,
  input  wire logic [1:0]  auto_mode_i,
  output logic [5:0]       third_hit_wave_o,
  output logic [5:0]       fourth_hit_wave_o,
  output logic [5:0]       fifth_hit_wave_o,
  output logic [5:0]       sixth_hit_wave_o,
  output logic [3:0]       hit_used_o,
  output logic [11:0]      comparator_threshold_o,
  output logic [5:0]       diff_cycles_o,
  output logic             diff_sequence_start_o,
  output logic             temp_cycle_start_o
);
  localparam logic [4:0] FRAME_LAST = 5'(ftcfg_pkg::SPI_FRAME - 1);
  localparam logic [4:0] OPC_LAST   = 5'd7;

  // map an opcode with the read flag stripped to a register index
  function automatic logic [2:0] reg_index(input logic [7:0] opc);
    reg_index = 3'(opc[6:0] - ftcfg_pkg::OFF_HIT_3_4[6:0]);
  endfunction : reg_index

  function automatic logic reg_hit(input logic [7:0] opc);
    reg_hit = (opc[6:0] >= ftcfg_pkg::OFF_HIT_3_4[6:0]) &&
              (opc[6:0] <= ftcfg_pkg::OFF_SCHED[6:0]);
  endfunction : reg_hit

  function automatic logic [15:0] reg_mask(input logic [2:0] idx);
    case (idx)
      3'd0, 3'd1: reg_mask = ftcfg_pkg::MASK_HIT;
      3'd2, 3'd3: reg_mask = ftcfg_pkg::MASK_OFS;
      default:    reg_mask = ftcfg_pkg::MASK_SCHED;
    endcase
  endfunction : reg_mask

  // pins cross into clk_i through two flops each
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_q    <= 3'b100;
      sync2_q    <= 3'b100;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {spi_cs_n_i, spi_sck_i, spi_mosi_i};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[1];
    end
  end
  logic cs_n;
  logic sck_rise;
  logic sck_fall;
  assign cs_n     = sync2_q[2];
  assign sck_rise = ~cs_n & sync2_q[1] & ~sck_prev_q;
  assign sck_fall = ~cs_n & ~sync2_q[1] & sck_prev_q;

  // frame: 8-bit opcode then 16-bit data, msb first, mode 0
  logic [4:0]  bit_cnt_q;
  logic [23:0] rx_q;
  logic [7:0]  opc_q;
  logic        frame_done;
  logic        opc_done;
  assign opc_done   = sck_rise & (bit_cnt_q == OPC_LAST);
  assign frame_done = sck_rise & (bit_cnt_q == FRAME_LAST);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cs_n) begin
      bit_cnt_q <= 5'd0;
      rx_q      <= 24'h000000;
    end else if (sck_rise) begin
      bit_cnt_q <= (bit_cnt_q == FRAME_LAST) ? 5'd0 : bit_cnt_q + 5'd1;
      rx_q      <= {rx_q[22:0], sync2_q[0]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      opc_q <= 8'h00;
    end else if (opc_done) begin
      opc_q <= {rx_q[6:0], sync2_q[0]};
    end
  end

  // register storage
  logic [15:0] regs_q [ftcfg_pkg::NUM_REGS];
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [15:0] wr_data;
  assign wr_en   = frame_done & ~opc_q[7] & reg_hit(opc_q);
  assign wr_idx  = reg_index(opc_q);
  assign wr_data = {rx_q[14:0], sync2_q[0]};
  generate
    for (genvar g = 0; g < ftcfg_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          regs_q[g] <= ftcfg_pkg::REG_RESET;
        end else if (wr_en && wr_idx == 3'(g)) begin
          regs_q[g] <= wr_data & reg_mask(3'(g));
        end
      end
    end
  endgenerate

  // read data loads after the opcode, shifts out on falling sck
  logic [15:0] tx_q;
  logic [7:0]  rd_opc;
  assign rd_opc = {rx_q[6:0], sync2_q[0]};
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_q <= 16'h0000;
    end else if (opc_done) begin
      // unmapped reads return zero
      tx_q <= (rd_opc[7] && reg_hit(rd_opc)) ?
              regs_q[reg_index(rd_opc)] : 16'h0000;
    end else if (sck_fall && bit_cnt_q > OPC_LAST) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      spi_miso_o <= 1'b0;
    end else if (sck_fall) begin
      spi_miso_o <= (bit_cnt_q > OPC_LAST) ? tx_q[15] : 1'b0;
    end
  end
  assign spi_miso_oe_o = ~cs_n;

  // hit wave selection
  logic [5:0] raw_wave [4];
  logic [5:0] clamped  [4];
  localparam logic [5:0] MINS [4] = '{ftcfg_pkg::HIT3_MIN,
    ftcfg_pkg::HIT4_MIN, ftcfg_pkg::HIT5_MIN, ftcfg_pkg::HIT6_MIN};
  assign raw_wave[0] = regs_q[0][ftcfg_pkg::HI_WAVE_LSB +: 6];
  assign raw_wave[1] = regs_q[0][ftcfg_pkg::LO_WAVE_LSB +: 6];
  assign raw_wave[2] = regs_q[1][ftcfg_pkg::HI_WAVE_LSB +: 6];
  assign raw_wave[3] = regs_q[1][ftcfg_pkg::LO_WAVE_LSB +: 6];
  generate
    for (genvar h = 0; h < 4; h++) begin : g_hit
      ftcfg_wave_clamp #(
        .MIN_WAVE (MINS[h])
      ) u_clamp (
        .code_i (raw_wave[h]),
        .wave_o (clamped[h])
      );
    end
  endgenerate
  // ordering between hits is the host's duty and is not checked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      third_hit_wave_o  <= ftcfg_pkg::HIT3_MIN;
      fourth_hit_wave_o <= ftcfg_pkg::HIT4_MIN;
      fifth_hit_wave_o  <= ftcfg_pkg::HIT5_MIN;
      sixth_hit_wave_o  <= ftcfg_pkg::HIT6_MIN;
    end else begin
      third_hit_wave_o  <= clamped[0];
      fourth_hit_wave_o <= clamped[1];
      fifth_hit_wave_o  <= clamped[2];
      sixth_hit_wave_o  <= clamped[3];
    end
  end
  // code 6 also means six hits; hits 3..6 need codes 2..5
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hit_used_o <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        hit_used_o[i] <= (stop_hits_i >= 3'(i + 2)) & (stop_hits_i != 3'd7);
      end
    end
  end

  // comparator threshold code
  logic [6:0] init_code;
  logic [7:0] ret_code;
  assign init_code = measure_up_i ? regs_q[2][ftcfg_pkg::INIT_LSB +: 7]
                                  : regs_q[3][ftcfg_pkg::INIT_LSB +: 7];
  assign ret_code  = measure_up_i ? regs_q[2][ftcfg_pkg::RET_LSB +: 8]
                                  : regs_q[3][ftcfg_pkg::RET_LSB +: 8];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      comparator_threshold_o <= ftcfg_pkg::THR_POS_BASE;
    end else if (early_edge_seen_i) begin
      // two's-complement return offset around the common mode base
      comparator_threshold_o <= ftcfg_pkg::THR_POS_BASE +
                                {{4{ret_code[7]}}, ret_code};
    end else if (!stop_edge_polarity_i) begin
      comparator_threshold_o <= ftcfg_pkg::THR_POS_BASE +
                                {5'h00, init_code};
    end else begin
      comparator_threshold_o <= ftcfg_pkg::THR_NEG_BASE -
                                {5'h00, init_code};
    end
  end

  // event schedule: millisecond enable, lfsr randomizer
  logic [16:0] ms_div_q;
  logic        ms_tick;
  assign ms_tick = (ms_div_q == 17'(CYC_PER_MS - 1));
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ms_tick) begin
      ms_div_q <= 17'h00000;
    end else begin
      ms_div_q <= ms_div_q + 17'h00001;
    end
  end
  logic [7:0] lfsr_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lfsr_q <= 8'h01;
    end else if (ms_tick) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end
  ftcfg_pkg::ftcfg_mode_t mode;
  assign mode = ftcfg_pkg::ftcfg_mode_t'(auto_mode_i);
  logic diff_on;
  logic temp_on;
  always_comb begin
    unique case (mode)
      ftcfg_pkg::FTCFG_IDLE:   {diff_on, temp_on} = 2'b00;
      ftcfg_pkg::FTCFG_BOTH:   {diff_on, temp_on} = 2'b11;
      ftcfg_pkg::FTCFG_FLIGHT: {diff_on, temp_on} = 2'b10;
      ftcfg_pkg::FTCFG_TEMP:   {diff_on, temp_on} = 2'b01;
    endcase
  end
  // random part kept under 128 ms; diff and temp starts can coincide, as on the first ms tick in FTCFG_BOTH
  logic [15:0] diff_reload;
  logic [15:0] temp_reload;
  assign diff_reload = 16'((32'(regs_q[4][ftcfg_pkg::DIFF_INT_LSB +: 4]) + 1)
                       * ftcfg_pkg::DIFF_STEP_MS) + {9'h000, lfsr_q[6:0]};
  assign temp_reload = 16'((32'(regs_q[4][ftcfg_pkg::TEMP_INT_LSB +: 6]) + 1)
                       * ftcfg_pkg::TEMP_STEP_MS) + {9'h000, lfsr_q[6:0]};
  logic [15:0] diff_cnt_q;
  logic [15:0] temp_cnt_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !diff_on) begin
      diff_cnt_q            <= 16'h0000;
      diff_sequence_start_o <= 1'b0;
    end else begin
      diff_sequence_start_o <= ms_tick && diff_cnt_q == 16'h0000;
      if (ms_tick) begin
        diff_cnt_q <= (diff_cnt_q == 16'h0000) ? diff_reload - 16'h0001
                                               : diff_cnt_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !temp_on) begin
      temp_cnt_q         <= 16'h0000;
      temp_cycle_start_o <= 1'b0;
    end else begin
      temp_cycle_start_o <= ms_tick && temp_cnt_q == 16'h0000;
      if (ms_tick) begin
        temp_cnt_q <= (temp_cnt_q == 16'h0000) ? temp_reload - 16'h0001
                                               : temp_cnt_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      diff_cycles_o <= 6'h01;
    end else begin
      diff_cycles_o <= {1'b0, regs_q[4][ftcfg_pkg::DIFF_CYC_LSB +: 5]} + 6'h01;
    end
  end

  // checks
  sequence s_write_frame;
    wr_en ##0 (wr_idx == 3'd1);
  endsequence
  a_reg_reset_zero: assert property (@(posedge clk_i)
    $past(sys_rst_i) |-> (regs_q[0] == 16'h0000 && regs_q[4] == 16'h0000))
    else $error("register not zero after reset");
  a_reserved_bits_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (regs_q[0] & ~ftcfg_pkg::MASK_HIT) == 16'h0000 &&
    (regs_q[2] & ~ftcfg_pkg::MASK_OFS) == 16'h0000 && !regs_q[4][0])
    else $error("reserved bit set");
  a_hit56_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_write_frame |=> ##1 (fifth_hit_wave_o ==
      ((regs_q[1][13:8] < 6'd7) ? 6'd7 : regs_q[1][13:8])))
    else $error("fifth hit wave not following write");
  a_hit4_clamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(regs_q[0]) |=> (fourth_hit_wave_o >= 6'd6) &&
      ($past(regs_q[0][5:0]) <= 6'd6 || fourth_hit_wave_o == $past(regs_q[0][5:0])))
    else $error("fourth hit clamp wrong");
  a_hit6_clamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (regs_q[1][5:0] <= 6'd8) [*2] |-> sixth_hit_wave_o == 6'd8)
    else $error("sixth hit clamp wrong");
  a_thr_init_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!early_edge_seen_i && !stop_edge_polarity_i && measure_up_i) |=>
      comparator_threshold_o == 12'd1152 + {5'h00, $past(regs_q[2][6:0])})
    else $error("rising initial threshold wrong");
  a_thr_init_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!early_edge_seen_i && stop_edge_polarity_i && !measure_up_i) |=>
      comparator_threshold_o == 12'd1151 - {5'h00, $past(regs_q[3][6:0])})
    else $error("falling initial threshold wrong");
  a_thr_return_up: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (early_edge_seen_i && measure_up_i) |=> comparator_threshold_o ==
      12'd1152 + {{4{$past(regs_q[2][15])}}, $past(regs_q[2][15:8])})
    else $error("return threshold wrong");
  a_diff_start_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (diff_sequence_start_o && diff_on) |=> !diff_sequence_start_o [*8])
    else $error("diff sequences too close");
  a_diff_cycles: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(regs_q[4]) |=> diff_cycles_o == {1'b0, $past(regs_q[4][11:7])} + 6'd1)
    else $error("diff cycle count wrong");
endmodule : ftcfg_top

// >>> test/ftcfg_host_model.sv
// host model: spi mode 0 master sending 24-bit register frames
`timescale 1ns/1ns
module ftcfg_host_model (
  input  wire logic clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_sck_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o
);
  // half period in clk; kept above the 3 clk the synchroniser needs
  localparam int HP = 5;
  initial begin
    spi_sck_o  = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b1;
  end
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {op, wd};
    rd = 16'h0000;
    @(negedge clk_i);
    spi_cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi_o = sh[i];
      repeat (HP) @(negedge clk_i);
      spi_sck_o = 1'b1;
      if (i < 16) rd[i] = spi_miso_i;
      repeat (HP) @(negedge clk_i);
      spi_sck_o = 1'b0;
    end
    repeat (HP) @(negedge clk_i);
    spi_cs_n_o = 1'b1;
    // released line shows the inverse so a stale bit is never reused
    spi_mosi_o = ~spi_mosi_o;
    repeat (8) @(negedge clk_i);
  endtask : xfer
endmodule : ftcfg_host_model

// >>> test/ftcfg_top_tb_top.sv
// testbench: register access, hit clamps, thresholds, hit usage, schedule
`timescale 1ns/1ns
module ftcfg_top_tb_top;
  localparam int         MS = 10;
  localparam logic [5:0] COR [5][4] = '{'{6'd0, 6'd1, 6'd2, 6'd3},
    '{6'd4, 6'd5, 6'd6, 6'd7}, '{6'd5, 6'd6, 6'd7, 6'd8},
    '{6'd6, 6'd7, 6'd8, 6'd9}, '{6'd60, 6'd61, 6'd62, 6'd63}};
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sck, cs_n, mosi, miso, miso_oe;
  logic        pol = 1'b0;
  logic        up = 1'b0;
  logic        early = 1'b0;
  logic [2:0]  hits = 3'h0;
  logic [1:0]  mode = 2'h0;
  logic [5:0]  w3, w4, w5, w6, dcyc;
  logic [3:0]  used;
  logic [11:0] thr;
  logic        dpulse, tpulse;
  int          fail_count = 0;
  int          n_tests = 0;
  int          nd = 0;
  int          nt = 0;
  int          noe = 0;
  always #5 clk_i = ~clk_i;
  ftcfg_host_model host_u (.clk_i(clk_i), .spi_miso_i(miso),
    .spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));
  ftcfg_top #(.CYC_PER_MS(MS)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .stop_edge_polarity_i(pol),
    .stop_hits_i(hits), .measure_up_i(up), .early_edge_seen_i(early),
    .auto_mode_i(mode), .third_hit_wave_o(w3), .fourth_hit_wave_o(w4),
    .fifth_hit_wave_o(w5), .sixth_hit_wave_o(w6), .hit_used_o(used),
    .comparator_threshold_o(thr), .diff_cycles_o(dcyc),
    .diff_sequence_start_o(dpulse), .temp_cycle_start_o(tpulse));
  always @(negedge clk_i) begin
    if (dpulse === 1'b1) nd++;
    if (tpulse === 1'b1) nt++;
    if (miso_oe === 1'b1) noe++;
  end
  function automatic logic [5:0] clampw(logic [5:0] c, logic [5:0] m);
    return (c < m) ? m : c;
  endfunction : clampw
  function automatic logic [11:0] thr_exp(logic [15:0] r, logic e, logic p);
    if (e) return 12'h480 + {{4{r[15]}}, r[15:8]};
    return p ? 12'h47f - {5'h00, r[6:0]} : 12'h480 + {5'h00, r[6:0]};
  endfunction : thr_exp
  function automatic logic [3:0] used_exp(logic [2:0] c);
    int n;
    n = (c == 3'h7) ? 0 : (c == 3'h6) ? 6 : int'(c) + 1;
    return {n >= 6, n >= 5, n >= 4, n >= 3};
  endfunction : used_exp
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic wr(logic [7:0] op, logic [15:0] d);
    logic [15:0] x;
    host_u.xfer(op, d, x);
  endtask : wr
  task automatic rdchk(logic [7:0] op, logic [15:0] exp);
    logic [15:0] x;
    host_u.xfer(op | 8'h80, 16'h0000, x);
    chk("register read", exp, x);
  endtask : rdchk
  // waits for one pulse, then counts clocks to the next one
  task automatic gap(string nm, logic t, int lo, int hi);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while ((t ? tpulse : dpulse) !== 1'b1 && n < 30000);
    end
    chk(nm, 16'h0001, 16'((n >= lo * MS - 2) && (n <= hi * MS + MS)));
  endtask : gap
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #1000000;
    fail_count++;
    close_out();
  end
  initial begin
    logic [5:0]  h [4];
    logic [15:0] ru, rn, s;
    logic [11:0] e;
    int          nd0, nt0;
    void'($urandom(32'hbda9));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk("oe in reset", 16'h0000, 16'(miso_oe));
    sys_rst_i = 1'b0;
    for (int i = 0; i < 5; i++) rdchk(8'h3b + 8'(i), 16'h0000);
    chk("oe idle", 16'h0000, 16'(miso_oe));
    chk("oe in frame", 16'h0001, 16'(noe > 0));
    chk("thr", 16'h0480, 16'(thr));
    chk("diff cycles", 16'h0001, 16'(dcyc));
    for (int k = 0; k < 13; k++) begin
      if (k < 5) begin
        h = COR[k];
      end else begin
        h[0] = 6'($urandom_range(47));
        h[1] = clampw(h[0], 6'h05) + 6'($urandom_range(4, 1));
        h[2] = clampw(h[1], 6'h06) + 6'($urandom_range(4, 1));
        h[3] = clampw(h[2], 6'h07) + 6'($urandom_range(4, 1));
      end
      // reserved bits written as ones to prove they are dropped
      wr(8'h3b, {2'b11, h[0], 2'b11, h[1]});
      wr(8'h3c, {2'b11, h[2], 2'b11, h[3]});
      rdchk(8'h3b, {2'b00, h[0], 2'b00, h[1]});
      rdchk(8'h3c, {2'b00, h[2], 2'b00, h[3]});
      chk("third wave", 16'(clampw(h[0], 6'h05)), 16'(w3));
      chk("fourth wave", 16'(clampw(h[1], 6'h06)), 16'(w4));
      chk("fifth wave", 16'(clampw(h[2], 6'h07)), 16'(w5));
      chk("sixth wave", 16'(clampw(h[3], 6'h08)), 16'(w6));
    end
    for (int r = 0; r < 4; r++) begin
      ru = (r == 0) ? 16'h80ff : 16'($urandom);
      rn = (r == 0) ? 16'h7fff : 16'($urandom);
      wr(8'h3d, ru);
      wr(8'h3e, rn);
      rdchk(8'h3d, ru & 16'hff7f);
      rdchk(8'h3e, rn & 16'hff7f);
      for (int c = 0; c < 8; c++) begin
        {up, early, pol} = 3'(c);
        repeat (3) @(negedge clk_i);
        s = up ? ru : rn;
        e = thr_exp(s, early, pol);
        chk("thr", 16'(e), 16'(thr));
      end
    end
    for (int c = 0; c < 8; c++) begin
      hits = 3'(c);
      repeat (3) @(negedge clk_i);
      chk("hits used", 16'(used_exp(hits)), 16'(used));
    end
    wr(8'h3a, 16'hffff);
    rdchk(8'h3b, {2'b00, h[0], 2'b00, h[1]});
    rdchk(8'h3a, 16'h0000);
    rdchk(8'h40, 16'h0000);
    s = {4'h0, 5'h1f, 6'h00, 1'b1};
    wr(8'h3f, s);
    rdchk(8'h3f, s & 16'hfffe);
    chk("diff cycles", 16'h0020, 16'(dcyc));
    mode = 2'b01;
    gap("diff gap", 1'b0, 500, 627);
    gap("temp gap", 1'b1, 1000, 1127);
    mode = 2'b00;
    s = {4'h1, 5'($urandom), 6'h01, 1'b0};
    wr(8'h3f, s);
    chk("diff cycles", 16'(s[11:7]) + 16'h0001, 16'(dcyc));
    nt0 = nt;
    mode = 2'b10;
    gap("diff gap", 1'b0, 1000, 1127);
    chk("temp pulses", 16'(nt0), 16'(nt));
    mode = 2'b00;
    repeat (4) @(negedge clk_i);
    nd0 = nd;
    mode = 2'b11;
    gap("temp gap", 1'b1, 2000, 2127);
    chk("diff pulses", 16'(nd0), 16'(nd));
    mode = 2'b00;
    close_out();
  end
endmodule : ftcfg_top_tb_top
